// ### logic/interval_counter.sv
// Purpose: Interval counter that pulses on each expiry and reloads itself
// Assumes: full_count is at least 2
// Notes: The first interval after start may be half a period
module interval_counter (
    // Clock and control
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Terminal count of one full interval
    input wire logic [serial_pkg::CNT_W-1:0] full_count,
    // Pacing link
    pace_if.timer pace
);

    logic [serial_pkg::CNT_W-1:0] cnt_q;
    logic [serial_pkg::CNT_W-1:0] lim_q;
    logic run_q;
    logic hit;

    // Expiry comes straight from the count, so the user acts on the
    // terminal edge itself and each interval is exactly lim_q cycles
    assign hit = run_q && (cnt_q == lim_q - 1'b1);
    assign pace.expire = hit;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
            lim_q <= '0;
            run_q <= 1'b0;
        end else if (ce) begin
            if (pace.start) begin
                cnt_q <= '0;
                run_q <= 1'b1;
                lim_q <= pace.half ? (full_count >> 1) : full_count;
            end else if (pace.stop) begin
                run_q <= 1'b0;
            end else if (hit) begin
                cnt_q <= '0;
                lim_q <= full_count;
            end else if (run_q) begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

endmodule // interval_counter

// ### logic/line_sampler.sv
// Purpose: Two-stage synchroniser for the receive pin with edge detection
// Assumes: Pin is asynchronous to clk
// Notes: Edges are taken from the second stage only
module line_sampler (
    // Clock and control
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Pin and synchronised results
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);

    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else if (ce) begin
            meta_q <= pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;

endmodule // line_sampler

// ### logic/pace_if.sv
// Purpose: Control and expiry signals between a pacing user and its counter
// Assumes: One clock domain
// Notes: start and stop are single-cycle requests; expire is a pulse
interface pace_if;
    logic start;
    logic half;
    logic stop;
    logic expire;

    modport user (output start, output half, output stop, input expire);
    modport timer (input start, input half, input stop, output expire);
endinterface

// ### logic/serial_pkg.sv
// Purpose: Shared constants and types of the timer-paced serial transceiver
// Assumes: 200 MHz system clock, 8 data bits, one start and one stop bit
// Notes: Frame bit positions count from the start bit at position 0
package serial_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_FREQ_HZ = 200_000_000;
    localparam int BAUD_RATE_BPS = 9600;
    // Terminal count of one bit interval: clock rate over baud rate
    localparam int BIT_CYCLES = CLK_FREQ_HZ / BAUD_RATE_BPS;
    localparam int CNT_W = 16;

    // ==========================================================
    // Frame layout
    // ==========================================================
    localparam int DATA_W = 8;
    localparam int TX_WORD_W = 16;
    localparam int RX_BITS_W = 11;
    localparam int START_POS = 0;
    localparam int DATA_POS = 1;
    localparam int PARITY_POS = 9;
    localparam int STOP_POS_PAR = 10;
    localparam int STOP_POS_NOPAR = 9;
    localparam logic [3:0] LAST_IDX_PAR = 4'ha;
    localparam logic [3:0] LAST_IDX_NOPAR = 4'h9;
    localparam logic [3:0] IDX_RESET = 4'h0;

    // ==========================================================
    // Configuration and states
    // ==========================================================
    typedef enum logic [1:0] {
        PAR_NONE = 2'b00,
        PAR_ZERO = 2'b01,
        PAR_ODD = 2'b10,
        PAR_EVEN = 2'b11
    } parity_mode_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_BITS = 2'b01,
        RX_CHECK = 2'b10
    } rx_state_t;

    typedef enum logic [0:0] {
        TX_IDLE = 1'b0,
        TX_SEND = 1'b1
    } tx_state_t;

endpackage

// ### logic/serial_transceiver.sv
// Purpose: Timer-paced asynchronous serial transmitter and receiver
// Assumes: Configuration inputs are held stable while a frame is in flight
// Notes: Bit period is a parameter so a simulation can shorten it

// Summary of operation
// R1: Reception begins on the configured valid edge of the receive line.
// R2: Interval terminal count equals clock frequency divided by baud rate.
// R3: Start bit sampled half a bit period after the start edge.
// R4: Samples after the start bit are one full bit period apart.
// R5: Each sampled level is stored in order in the receive register.
// R6: After stop bit, flag framing error and, if enabled, parity mismatch.
// R7: Without error, extract 8-bit character per order and polarity, deliver.
// R8: Transmit word: start, 8 data, optional parity, stop from bit 0.
// R9: Transmit word follows bit order, parity mode and line polarity.
// R10: Each transmit interval expiry drives the next word bit, from bit 0.
// R11: Character done once stop bit held one period; completion reported.
// R12: Transmit and receive use two independent interval counters.
// R13: Configuring party selects exactly one option per configurable item.
// R14: Tx idles high, rx starts on rise; inverted polarity flips both.
// R15: Inverted polarity complements received bits before any check.
// R16: Odd parity makes ones odd, even makes even, zero mode sends 0.
// R17: Without parity the stop bit directly follows the eighth data bit.
module serial_transceiver #(
    parameter int BIT_CYCLES = serial_pkg::BIT_CYCLES
) (
    // Clock, reset and clock enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Configuration
    input wire logic msb_first,
    input wire logic [1:0] parity_mode,
    input wire logic invert,
    // Serial pins
    input wire logic receive_line,
    output logic transmit_line,
    // Transmit request
    input wire logic tx_valid,
    input wire logic [serial_pkg::DATA_W-1:0] tx_data,
    output logic tx_ready,
    output logic tx_done,
    // Receive results
    output logic [serial_pkg::DATA_W-1:0] rx_data,
    output logic rx_valid,
    output logic rx_framing_err,
    output logic rx_parity_err,
    output logic rx_busy
);

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [7:0] order_bits(input logic [7:0] d,
                                              input logic msb);
        logic [7:0] r;
        r = d;
        if (msb) begin
            for (int i = 0; i < 8; i++) begin
                r[i] = d[7 - i];
            end
        end
        return r;
    endfunction

    // Parity bit for a character under the given mode
    function automatic logic parity_of(input logic [7:0] d,
                                       input logic [1:0] mode);
        logic p;
        p = 1'b0;
        case (mode)
            serial_pkg::PAR_ODD: p = ~^d; // R16
            serial_pkg::PAR_EVEN: p = ^d; // R16
            default: p = 1'b0; // R16
        endcase
        return p;
    endfunction

    // ==========================================================
    // Shared decode
    // ==========================================================
    logic par_en;
    logic idle_level;
    logic [3:0] last_idx;
    logic [serial_pkg::CNT_W-1:0] full_count;

    assign par_en = (parity_mode != serial_pkg::PAR_NONE);
    assign idle_level = ~invert; // R14
    assign last_idx = par_en ? serial_pkg::LAST_IDX_PAR
                             : serial_pkg::LAST_IDX_NOPAR; // R17
    assign full_count = serial_pkg::CNT_W'(BIT_CYCLES); // R2

    // ==========================================================
    // Interval counters
    // ==========================================================
    pace_if tx_pace ();
    pace_if rx_pace ();

    interval_counter u_tx_timer ( // R12
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .full_count(full_count),
        .pace(tx_pace.timer)
    );

    interval_counter u_rx_timer ( // R12
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .full_count(full_count),
        .pace(rx_pace.timer)
    );

    // ==========================================================
    // Receive pin
    // ==========================================================
    logic rx_level;
    logic rx_rise;
    logic rx_fall;

    line_sampler u_rx_pin (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .pin(receive_line),
        .level(rx_level),
        .rise(rx_rise),
        .fall(rx_fall)
    );

    // ==========================================================
    // Receiver
    // ==========================================================
    serial_pkg::rx_state_t rx_state_q;
    serial_pkg::rx_state_t rx_state_d;
    logic [serial_pkg::RX_BITS_W-1:0] rx_bits_q;
    logic [3:0] rx_idx_q;
    logic [serial_pkg::DATA_W-1:0] rx_data_q;
    logic rx_valid_q;
    logic rx_ferr_q;
    logic rx_perr_q;
    logic rx_busy_q;

    logic start_edge_detect;
    logic rx_go;
    logic rx_last;
    logic [serial_pkg::RX_BITS_W-1:0] rx_frame;
    logic [7:0] rx_raw;
    logic rx_stop_bit;
    logic rx_par_bit;
    logic rx_ferr;
    logic rx_perr;

    assign start_edge_detect = invert ? rx_fall : rx_rise; // R1 R14
    assign rx_go = (rx_state_q == serial_pkg::RX_IDLE) && start_edge_detect;
    assign rx_last = rx_pace.expire && (rx_idx_q == last_idx);

    // Half period first, then full periods by reload
    assign rx_pace.start = rx_go; // R1
    assign rx_pace.half = 1'b1; // R3 R4
    assign rx_pace.stop = rx_last;

    assign rx_frame = invert ? ~rx_bits_q : rx_bits_q; // R15
    assign rx_raw = rx_frame[serial_pkg::DATA_POS +: 8];
    assign rx_par_bit = rx_frame[serial_pkg::PARITY_POS];
    assign rx_stop_bit = par_en ? rx_frame[serial_pkg::STOP_POS_PAR]
                                : rx_frame[serial_pkg::STOP_POS_NOPAR]; // R17
    assign rx_ferr = ~rx_stop_bit; // R6
    assign rx_perr = par_en &&
                     (rx_par_bit != parity_of(rx_raw, parity_mode)); // R6

    always_comb begin
        rx_state_d = rx_state_q;
        case (rx_state_q)
            serial_pkg::RX_IDLE: begin
                if (rx_go) begin
                    rx_state_d = serial_pkg::RX_BITS;
                end
            end
            serial_pkg::RX_BITS: begin
                if (rx_last) begin
                    rx_state_d = serial_pkg::RX_CHECK;
                end
            end
            serial_pkg::RX_CHECK: rx_state_d = serial_pkg::RX_IDLE;
            default: rx_state_d = serial_pkg::RX_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_state_q <= serial_pkg::RX_IDLE;
            rx_idx_q <= serial_pkg::IDX_RESET;
            rx_bits_q <= '0;
        end else if (ce) begin
            rx_state_q <= rx_state_d;
            if (rx_go) begin
                rx_idx_q <= serial_pkg::IDX_RESET;
                rx_bits_q <= '0;
            end else if (rx_state_q == serial_pkg::RX_BITS &&
                         rx_pace.expire) begin
                rx_bits_q[rx_idx_q] <= rx_level; // R5
                rx_idx_q <= rx_idx_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_data_q <= '0;
            rx_valid_q <= 1'b0;
            rx_ferr_q <= 1'b0;
            rx_perr_q <= 1'b0;
            rx_busy_q <= 1'b0;
        end else if (ce) begin
            rx_valid_q <= 1'b0;
            rx_ferr_q <= 1'b0;
            rx_perr_q <= 1'b0;
            rx_busy_q <= (rx_state_d != serial_pkg::RX_IDLE);
            if (rx_state_q == serial_pkg::RX_CHECK) begin
                rx_ferr_q <= rx_ferr; // R6
                rx_perr_q <= rx_perr; // R6
                if (!rx_ferr && !rx_perr) begin
                    rx_data_q <= order_bits(rx_raw, msb_first); // R7
                    rx_valid_q <= 1'b1; // R7
                end
            end
        end
    end

    assign rx_data = rx_data_q;
    assign rx_valid = rx_valid_q;
    assign rx_framing_err = rx_ferr_q;
    assign rx_parity_err = rx_perr_q;
    assign rx_busy = rx_busy_q;

    // ==========================================================
    // Transmitter
    // ==========================================================
    serial_pkg::tx_state_t tx_state_q;
    logic [serial_pkg::TX_WORD_W-1:0] tx_word_q;
    logic [serial_pkg::TX_WORD_W-1:0] tx_word_d;
    logic [3:0] tx_idx_q;
    logic tx_line_q;
    logic tx_ready_q;
    logic tx_done_q;
    logic [7:0] tx_ordered;
    logic tx_take;
    logic tx_end;

    assign tx_take = (tx_state_q == serial_pkg::TX_IDLE) && tx_ready_q &&
                     tx_valid;
    assign tx_end = (tx_state_q == serial_pkg::TX_SEND) &&
                    tx_pace.expire && (tx_idx_q == last_idx); // R11
    assign tx_ordered = order_bits(tx_data, msb_first); // R9

    // Unused upper bits hold the stop level so the line stays idle
    always_comb begin
        tx_word_d = {serial_pkg::TX_WORD_W{1'b1}};
        tx_word_d[serial_pkg::START_POS] = 1'b0; // R8
        tx_word_d[serial_pkg::DATA_POS +: 8] = tx_ordered; // R8
        if (par_en) begin
            tx_word_d[serial_pkg::PARITY_POS] =
                parity_of(tx_data, parity_mode); // R8 R16
        end
        if (invert) begin
            tx_word_d = ~tx_word_d; // R9
        end
    end

    assign tx_pace.start = tx_take;
    assign tx_pace.half = 1'b0;
    assign tx_pace.stop = tx_end;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_state_q <= serial_pkg::TX_IDLE;
            tx_word_q <= '0;
            tx_idx_q <= serial_pkg::IDX_RESET;
            tx_line_q <= 1'b1;
            tx_ready_q <= 1'b0;
            tx_done_q <= 1'b0;
        end else if (ce) begin
            tx_done_q <= 1'b0;
            case (tx_state_q)
                serial_pkg::TX_IDLE: begin
                    tx_line_q <= idle_level; // R14
                    tx_ready_q <= 1'b1;
                    if (tx_take) begin
                        tx_word_q <= tx_word_d;
                        tx_idx_q <= serial_pkg::IDX_RESET;
                        tx_line_q <= tx_word_d[0]; // R10
                        tx_ready_q <= 1'b0;
                        tx_state_q <= serial_pkg::TX_SEND;
                    end
                end
                serial_pkg::TX_SEND: begin
                    if (tx_end) begin
                        tx_line_q <= idle_level;
                        tx_done_q <= 1'b1; // R11
                        tx_ready_q <= 1'b1;
                        tx_state_q <= serial_pkg::TX_IDLE;
                    end else if (tx_pace.expire) begin
                        tx_idx_q <= tx_idx_q + 1'b1;
                        tx_line_q <= tx_word_q[tx_idx_q + 1'b1]; // R10
                    end
                end
                default: tx_state_q <= serial_pkg::TX_IDLE;
            endcase
        end
    end

    assign transmit_line = tx_line_q;
    assign tx_ready = tx_ready_q;
    assign tx_done = tx_done_q;

endmodule // serial_transceiver

// ### sim/serial_peer.sv
// Purpose: Opposite serial device on the receive and transmit pins
// Assumes: Same bit period as the device
// Notes: Idle level equals invert, so a normal frame opens with a rise
module serial_peer #(
    parameter int BIT_CYCLES = 16
) (
    // Clock and polarity
    input wire logic clk,
    input wire logic invert,
    // Serial pins
    output logic rx_pin,
    input wire logic tx_pin
);
    logic sending = 1'b0;
    logic bit_q = 1'b0;
    assign rx_pin = sending ? bit_q : invert;

    // Drive n frame bits, one bit period each
    task automatic send(input logic [10:0] w, input int n);
        @(posedge clk);
        #1;
        sending = 1'b1;
        for (int k = 0; k < n; k++) begin
            bit_q = w[k];
            repeat (BIT_CYCLES) @(posedge clk);
            #1;
        end
        sending = 1'b0;
    endtask

    // Sample n transmit bits at their centres; call just after the take
    task automatic capture(input int n, output logic [10:0] w);
        w = '0;
        for (int k = 0; k < n; k++) begin
            repeat (k == 0 ? BIT_CYCLES / 2 : BIT_CYCLES) @(posedge clk);
            #1;
            w[k] = tx_pin;
        end
    endtask
endmodule // serial_peer

// ### sim/serial_transceiver_checker.sv
// Purpose: Port-level assertions for the serial transceiver
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to serial_transceiver after the module
module serial_transceiver_checker #(
    parameter int BIT_CYCLES = 16
) (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Configuration
    input wire logic msb_first,
    input wire logic [1:0] parity_mode,
    input wire logic invert,
    // Serial pins
    input wire logic receive_line,
    input wire logic transmit_line,
    // Transmit
    input wire logic tx_valid,
    input wire logic [serial_pkg::DATA_W-1:0] tx_data,
    input wire logic tx_ready,
    input wire logic tx_done,
    // Receive
    input wire logic [serial_pkg::DATA_W-1:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_framing_err,
    input wire logic rx_parity_err,
    input wire logic rx_busy
);
    // ==========
    // Helper logic
    // ==========
    int tx_cnt_q;
    int rb_cnt_q;
    int nbits;
    int span;
    logic take;
    logic res;
    assign take = ce && tx_valid && tx_ready;
    assign res = rx_valid || rx_framing_err || rx_parity_err;
    assign nbits = (parity_mode == 2'h0) ? 10 : 11;
    assign span = BIT_CYCLES / 2 + (nbits - 1) * BIT_CYCLES;

    // Cycles since the transmit request was taken
    always_ff @(posedge clk) begin
        if (!rst_n || take) begin
            tx_cnt_q <= 0;
        end else if (!tx_ready) begin
            tx_cnt_q <= tx_cnt_q + 1;
        end
    end

    // Length of the current receive frame
    always_ff @(posedge clk) begin
        if (!rst_n || !rx_busy) begin
            rb_cnt_q <= 0;
        end else begin
            rb_cnt_q <= rb_cnt_q + 1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ==========
    // Assertions
    // ==========
    tx_take_start_a: assert property (
        take |=> !tx_ready && transmit_line == invert)
        else $error("transmit did not open with the start bit");
    tx_idle_level_a: assert property (
        tx_ready && $past(tx_ready) && $stable(invert)
        |-> transmit_line == !invert)
        else $error("transmit idle level wrong");
    tx_done_time_a: assert property (
        tx_done |-> tx_cnt_q == nbits * BIT_CYCLES)
        else $error("transmit completion at wrong cycle");
    tx_done_pulse_a: assert property (
        $rose(tx_done) |-> $rose(tx_ready) ##1 !tx_done)
        else $error("transmit completion pulse malformed");
    tx_bit_hold_a: assert property (
        !tx_ready && $changed(transmit_line)
        |-> tx_cnt_q % BIT_CYCLES == 0)
        else $error("transmit bit changed inside its period");
    rx_valid_clean_a: assert property (
        rx_valid |-> !rx_framing_err && !rx_parity_err && !rx_busy)
        else $error("receive delivered with an error");
    rx_pulse_once_a: assert property (
        res |=> !res)
        else $error("receive result longer than one cycle");
    rx_data_hold_a: assert property (
        $changed(rx_data) |-> rx_valid)
        else $error("receive data changed without delivery");
    rx_parity_off_a: assert property (
        rx_parity_err |-> parity_mode != 2'h0)
        else $error("parity error with parity disabled");
    rx_frame_span_a: assert property (
        $fell(rx_busy) |-> rb_cnt_q >= span - 2 && rb_cnt_q <= span + 3)
        else $error("receive frame length wrong");
    rx_result_due_a: assert property (
        $fell(rx_busy) |-> ##[0:3] res)
        else $error("no receive result after frame");

    tx_done_c: cover property (tx_done);
    rx_valid_c: cover property (rx_valid);
    rx_both_err_c: cover property (rx_framing_err && rx_parity_err);
    overlap_c: cover property (!tx_ready && rx_busy);
endmodule // serial_transceiver_checker

bind serial_transceiver serial_transceiver_checker #(
    .BIT_CYCLES(BIT_CYCLES)
) chk_u (
    .clk, .rst_n, .ce, .msb_first, .parity_mode, .invert,
    .receive_line, .transmit_line, .tx_valid, .tx_data, .tx_ready,
    .tx_done, .rx_data, .rx_valid, .rx_framing_err, .rx_parity_err,
    .rx_busy
);

// ### sim/tb_timer_paced_async_serial.sv
// Purpose: Self-checking bench of the serial transceiver
// Assumes: Bit period shortened to 16 clocks
// Notes: Transmit and receive run side by side in every configuration
module tb_timer_paced_async_serial;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int B = 16;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic msb_first = 1'b0;
    logic [1:0] parity_mode = 2'h0;
    logic invert = 1'b0;
    logic tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic receive_line, transmit_line, tx_ready, tx_done;
    logic rx_valid, rx_framing_err, rx_parity_err, rx_busy;
    logic [7:0] rx_data;
    logic got_v, got_f, got_p;
    int fails = 0;
    int num_checks = 0;

    always #2.5 clk = ~clk;

    serial_transceiver #(.BIT_CYCLES(B)) dut_u (
        .clk, .rst_n, .ce, .msb_first, .parity_mode, .invert,
        .receive_line, .transmit_line, .tx_valid, .tx_data, .tx_ready,
        .tx_done, .rx_data, .rx_valid, .rx_framing_err, .rx_parity_err,
        .rx_busy
    );

    serial_peer #(.BIT_CYCLES(B)) peer_u (
        .clk, .invert, .rx_pin(receive_line), .tx_pin(transmit_line)
    );

    // Catch one-cycle receive results
    always @(posedge clk) begin
        if (rx_valid === 1'b1) got_v <= 1'b1;
        if (rx_framing_err === 1'b1) got_f <= 1'b1;
        if (rx_parity_err === 1'b1) got_p <= 1'b1;
    end

    // ==========
    // Helpers
    // ==========
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        if (fails == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    function automatic int nb();
        return (parity_mode == 2'h0) ? 10 : 11;
    endfunction

    // Frame bits from bit 0 upward, line levels after polarity
    function automatic logic [10:0] frame(input logic [7:0] d,
        input logic st, input logic sp, input logic pf);
        logic [10:0] w;
        logic p;
        w = '0;
        w[0] = st;
        for (int i = 0; i < 8; i++) w[1 + i] = msb_first ? d[7 - i] : d[i];
        p = (parity_mode == 2'h2) ? ~^d : (parity_mode == 2'h3) ? ^d : 1'b0;
        if (parity_mode != 2'h0) begin
            w[9] = p ^ pf;
            w[10] = sp;
        end else begin
            w[9] = sp;
        end
        w = w ^ {11{invert}};
        return (nb() == 11) ? w : {1'b0, w[9:0]};
    endfunction

    // One option for each item, then let the pins settle
    task automatic set_cfg(input logic inv, input logic msb,
        input logic [1:0] mode);
        @(posedge clk);
        #1;
        invert = inv;
        msb_first = msb;
        parity_mode = mode;
        repeat (4) @(posedge clk);
    endtask

    // ==========
    // Scenarios
    // ==========
    // Clock enable low freezes the block, so a request is not taken
    task automatic ce_case();
        @(posedge clk);
        #1;
        ce = 1'b0;
        tx_valid = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check({tx_ready, transmit_line}, {1'b1, ~invert});
        tx_valid = 1'b0;
        ce = 1'b1;
        @(posedge clk);
        #1;
        check({tx_ready, transmit_line}, {1'b1, ~invert});
    endtask

    task automatic tx_case(input logic [7:0] d);
        logic [10:0] w;
        int i;
        @(posedge clk);
        #1;
        tx_valid = 1'b1;
        tx_data = d;
        for (i = 0; i < 40 && tx_ready !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 40) begin
            fails++;
            report_and_stop();
        end
        @(posedge clk);
        #1;
        tx_valid = 1'b0;
        peer_u.capture(nb(), w);
        check(w, frame(d, 1'b0, 1'b1, 1'b0));
        repeat (B / 2) @(posedge clk);
        #1;
        check({tx_done, tx_ready}, 2'b11);
        @(posedge clk);
        #1;
        check({tx_done, transmit_line}, {1'b0, ~invert});
    endtask

    task automatic rx_case(input logic [7:0] d, input logic sp,
        input logic pf, input logic [2:0] exp);
        logic [7:0] old;
        old = rx_data;
        got_v = 1'b0;
        got_f = 1'b0;
        got_p = 1'b0;
        peer_u.send(frame(d, 1'b1, sp, pf), nb());
        repeat (4) @(posedge clk);
        #1;
        check({got_v, got_f, got_p}, exp);
        check(rx_data, exp[2] ? d : old);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check({tx_ready, transmit_line, rx_busy}, 3'b110);
        ce_case();
        for (int c = 0; c < 16; c++) begin
            set_cfg(c[0], c[1], c[3:2]);
            fork
                tx_case(8'h80 ^ (8'h1d * c[7:0]));
                rx_case(8'h4f ^ (8'h25 * c[7:0]), 1'b1, 1'b0, 3'b100);
            join
        end
        set_cfg(1'b0, 1'b0, 2'h2);
        rx_case(8'h54, 1'b1, 1'b1, 3'b001);
        rx_case(8'h74, 1'b0, 1'b0, 3'b010);
        rx_case(8'h74, 1'b0, 1'b1, 3'b011);
        set_cfg(1'b1, 1'b1, 2'h1);
        rx_case(8'h01, 1'b1, 1'b1, 3'b001);
        set_cfg(1'b1, 1'b0, 2'h0);
        rx_case(8'hff, 1'b0, 1'b0, 3'b010);
        rx_case(8'h00, 1'b1, 1'b0, 3'b100);
        report_and_stop();
    end
endmodule // tb_timer_paced_async_serial
